// [verilog/core_decoder_pkg.sv]
// constants and types for the instruction decoder
//
// Contract
// - most instructions one word, four take two
// - word splits into opcode and operand fields
// - lone second word (1111 top) is a no-op
// - destination bit picks accumulator or register
// - access bit picks access RAM or bank
// - bank register holds selected RAM bank
// - bit field picks bit 0 to 7
// - register field is address or pointer selector
// - register moves use full 12-bit addresses
// - literal is 8, 12 or 20 bits
// - literal-to-pointer picks pointer by register field
// - branch offset signed, call/goto target absolute
// - table update mode has four behaviours
// - five arithmetic status flags are reported
// - taken test or jump adds one no-op cycle
// - two-word instructions take two cycles
// - instruction cycle is four clock periods
// - base set plus eight extended instructions
// - fast bit selects shadow register save/restore
package core_decoder_pkg;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int LIT_W  = 20;
    localparam int FLAG_N = 5;
    localparam int APB_AW = 8;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [3:0] SECOND_MARK = 4'hF;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BANK = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0C;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_EXT_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_DIGIT = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_OVER = 3;
    localparam int FLAG_NEG = 4;

    typedef enum logic [3:0] {
        CLS_NOP    = 4'b0000,
        CLS_BYTE   = 4'b0001,
        CLS_BIT    = 4'b0010,
        CLS_LIT    = 4'b0011,
        CLS_LFSR   = 4'b0100,
        CLS_MOVFF  = 4'b0101,
        CLS_GOTO   = 4'b0110,
        CLS_CALL   = 4'b0111,
        CLS_BRANCH = 4'b1000,
        CLS_TABLE  = 4'b1001,
        CLS_RETURN = 4'b1010,
        CLS_MISC   = 4'b1011,
        CLS_EXT    = 4'b1100
    } instr_class_t;

    typedef enum logic [1:0] {
        LW_NONE = 2'b00, LW_8 = 2'b01, LW_12 = 2'b10, LW_20 = 2'b11
    } lit_width_t;

    typedef enum logic [1:0] {
        TBL_KEEP = 2'b00, TBL_POST_INC = 2'b01,
        TBL_POST_DEC = 2'b10, TBL_PRE_INC = 2'b11
    } tbl_update_t;

    typedef enum logic {SEQ_FIRST = 1'b0, SEQ_SECOND = 1'b1} seq_state_t;

    typedef struct packed {
        instr_class_t      cls;
        logic [7:0]        opcode;
        logic              to_register;
        logic              use_bank;
        logic [7:0]        reg_addr;
        logic [ADDR_W-1:0] data_addr;
        logic [ADDR_W-1:0] dest_addr;
        logic [2:0]        bit_pos;
        logic [1:0]        ptr_sel;
        logic [LIT_W-1:0]  literal;
        lit_width_t        lit_width;
        logic              relative;
        logic [LIT_W-1:0]  target;
        logic              fast;
        tbl_update_t       tbl_mode;
        logic              tbl_write;
        logic [1:0]        cycles;
        logic              pending;
    } decoded_t;
endpackage

// [verilog/core_instruction_decoder.sv]
// instruction decoder with apb control and status registers
`timescale 1ns/1ns
module core_instruction_decoder
    import core_decoder_pkg::*;
#(
    parameter int COUNT_W = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [15:0]       instr_word,
    input  wire logic              instr_valid,
    input  wire logic              redirect,
    input  wire logic              bank_we,
    input  wire logic [BANK_W-1:0] bank_wdata,
    input  wire logic [FLAG_N-1:0] flags_in,
    input  wire logic [FLAG_N-1:0] flags_we,
    output decoded_t               dec,
    output logic                   dec_valid,
    output logic                   cycle_tick,
    output logic [FLAG_N-1:0]      status_flags,
    output logic [BANK_W-1:0]      bank_select_register
);

    if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_count
        $error("COUNT_W must lie in 1..32");
    end

    // ************************************************************
    // instruction cycle phase
    // ************************************************************
    logic [1:0] phase;
    logic       tick_now;

    assign tick_now = ce && (phase == PHASE_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 2'h0;
        end else if (ce) begin
            phase <= phase + 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_tick <= 1'b0;
        end else if (ce) begin
            cycle_tick <= tick_now;
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    logic [1:0]         ctrl;
    logic [COUNT_W-1:0] instr_count;
    logic               flush_req;
    logic               ctrl_en;
    logic               ext_en;
    logic               take;
    logic               flush_now;
    logic               apb_access;
    logic               apb_write;

    assign ctrl_en    = ctrl[CTRL_EN_BIT];
    assign ext_en     = ctrl[CTRL_EXT_BIT];
    assign take       = instr_valid && ctrl_en;
    assign flush_now  = flush_req || redirect;
    assign apb_access = psel && penable;
    assign apb_write  = apb_access && pready && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (ce && apb_write && paddr == OFF_CTRL) begin
            ctrl <= pwdata[1:0];
        end
    end

    // datapath bank loads win over software writes in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_select_register <= BANK_RESET;
        end else if (ce && bank_we) begin
            bank_select_register <= bank_wdata;
        end else if (ce && apb_write && paddr == OFF_BANK) begin
            bank_select_register <= pwdata[BANK_W-1:0];
        end
    end

    // a redirect in the consuming cycle is kept, the set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_req <= 1'b0;
        end else if (ce) begin
            flush_req <= redirect || (flush_req && !(tick_now && take));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_count <= '0;
        end else if (tick_now && take) begin
            instr_count <= instr_count + 1'b1;
        end
    end

    // ************************************************************
    // status flags
    // ************************************************************
    for (genvar i = 0; i < FLAG_N; i++) begin : g_flag
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                status_flags[i] <= 1'b0;
            end else if (ce && flags_we[i]) begin
                status_flags[i] <= flags_in[i];
            end
        end
    end

    // ************************************************************
    // word decode
    // ************************************************************
    seq_state_t seq;
    logic [15:0] first_word;
    logic [15:0] src;
    decoded_t    next_dec;

    function automatic logic two_word(input logic [15:0] w);
        two_word = (w[15:12] == 4'hC) || (w[15:10] == 6'b111011);
    endfunction

    assign src = (seq == SEQ_SECOND) ? first_word : instr_word;

    always_comb begin
        next_dec = '0;
        next_dec.cls = CLS_NOP;
        next_dec.lit_width = LW_NONE;
        next_dec.tbl_mode = TBL_KEEP;
        next_dec.cycles = CYC_ONE;
        next_dec.opcode = src[15:8];
        next_dec.to_register = src[9];
        next_dec.use_bank = src[8];
        next_dec.reg_addr = src[7:0];
        next_dec.bit_pos = src[11:9];
        next_dec.ptr_sel = src[5:4];
        next_dec.literal = {12'h000, src[7:0]};
        if (src[8]) begin
            next_dec.data_addr = {bank_select_register, src[7:0]};
        end else if (src[7:0] < ACCESS_SPLIT) begin
            next_dec.data_addr = {ACCESS_LOW_BANK, src[7:0]};
        end else begin
            next_dec.data_addr = {ACCESS_HIGH_BANK, src[7:0]};
        end
        unique case (src[15:12])
            4'h0: begin
                if (src[11:8] == 4'h0) begin
                    if (src[7:3] == 5'b00001) begin
                        next_dec.cls = CLS_TABLE;
                        next_dec.tbl_write = src[2];
                        next_dec.tbl_mode = tbl_update_t'(src[1:0]);
                    end else if (src[7:2] == 6'b000100) begin
                        next_dec.cls = CLS_RETURN;
                        next_dec.fast = src[0];
                        next_dec.cycles = CYC_TWO;
                    end else if (src[7:0] == 8'h14) begin
                        next_dec.cls = ext_en ? CLS_EXT : CLS_NOP;
                    end else begin
                        next_dec.cls = CLS_MISC;
                    end
                end else if (src[11:9] == 3'b000 || src[11]) begin
                    next_dec.cls = CLS_LIT;
                    next_dec.lit_width = LW_8;
                end else begin
                    next_dec.cls = CLS_BYTE;
                end
            end
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
                next_dec.cls = CLS_BYTE;
            end
            4'h7, 4'h8, 4'h9, 4'hA, 4'hB: begin
                next_dec.cls = CLS_BIT;
            end
            4'hC: begin
                next_dec.cls = CLS_MOVFF;
                next_dec.use_bank = 1'b0;
                next_dec.to_register = 1'b1;
                next_dec.data_addr = src[11:0];
            end
            4'hD: begin
                next_dec.cls = CLS_BRANCH;
                next_dec.relative = 1'b1;
                next_dec.target = {{9{src[10]}}, src[10:0]};
                next_dec.cycles = CYC_TWO;
            end
            4'hE: begin
                unique case (src[11:10])
                    2'b00, 2'b01: begin
                        next_dec.cls = CLS_BRANCH;
                        next_dec.relative = 1'b1;
                        next_dec.target = {{12{src[7]}}, src[7:0]};
                    end
                    2'b10: begin
                        next_dec.cls = ext_en ? CLS_EXT : CLS_NOP;
                    end
                    2'b11: begin
                        if (src[9:8] == 2'b10) begin
                            next_dec.cls = CLS_LFSR;
                            next_dec.lit_width = LW_12;
                            next_dec.literal = {16'h0000, src[3:0]};
                        end else begin
                            next_dec.cls = src[9] ? CLS_GOTO : CLS_CALL;
                            next_dec.fast = !src[9] && src[8];
                            next_dec.lit_width = LW_20;
                            next_dec.target = {12'h000, src[7:0]};
                        end
                    end
                endcase
            end
            4'hF: begin
                next_dec.cls = CLS_NOP;
            end
        endcase
        if (two_word(src)) begin
            next_dec.cycles = CYC_TWO;
            next_dec.pending = (seq == SEQ_FIRST);
            if (seq == SEQ_SECOND) begin
                next_dec.dest_addr = instr_word[11:0];
                if (next_dec.cls == CLS_LFSR) begin
                    next_dec.literal = {8'h00, src[3:0], instr_word[7:0]};
                end else begin
                    next_dec.target = {instr_word[11:0], src[7:0]};
                    next_dec.literal = {instr_word[11:0], src[7:0]};
                end
            end
        end
        if (flush_now) begin
            next_dec = '0;
            next_dec.cls = CLS_NOP;
            next_dec.cycles = CYC_ONE;
        end
    end

    // ************************************************************
    // word sequencing
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq <= SEQ_FIRST;
            first_word <= 16'h0000;
        end else if (tick_now && take) begin
            if (flush_now) begin
                seq <= SEQ_FIRST;
            end else begin
                unique case (seq)
                    SEQ_FIRST: begin
                        if (two_word(instr_word)) begin
                            seq <= SEQ_SECOND;
                            first_word <= instr_word;
                        end
                    end
                    SEQ_SECOND: begin
                        seq <= SEQ_FIRST;
                    end
                endcase
            end
        end
    end

    // decoded fields stand until the next instruction cycle that takes a word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec <= '0;
            dec_valid <= 1'b0;
        end else if (tick_now) begin
            dec_valid <= take;
            if (take) begin
                dec <= next_dec;
            end
        end
    end

    // ************************************************************
    // apb slave, one wait state
    // ************************************************************
    logic        hit;
    logic [31:0] rd_mux;

    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            OFF_CTRL: rd_mux = {30'h0, ctrl};
            OFF_BANK: rd_mux = {{(32-BANK_W){1'b0}}, bank_select_register};
            OFF_STATUS: rd_mux = {25'h0, flush_req, seq == SEQ_SECOND, status_flags};
            OFF_COUNT: rd_mux = 32'(instr_count);
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else if (ce) begin
            pready <= apb_access && !pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce && apb_access && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !hit;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_cycle_period: assert property (
        cycle_tick && ce |=> !cycle_tick [*3] ##1 !ce || cycle_tick)
        else $error("instruction cycle is not four clocks");

    chk_second_nop: assert property (
        tick_now && take && !flush_now && seq == SEQ_FIRST
        && instr_word[15:12] == SECOND_MARK |=> dec.cls == CLS_NOP && dec_valid)
        else $error("lone second word not decoded as no-op");

    chk_two_word_pend: assert property (
        tick_now && take && !flush_now && seq == SEQ_FIRST && two_word(instr_word)
        |=> dec.pending && dec.cycles == CYC_TWO && seq == SEQ_SECOND)
        else $error("two-word start not flagged pending");

    chk_bank_source: assert property (
        $past(tick_now) && dec_valid && dec.cls == CLS_BYTE && dec.use_bank
        |-> dec.data_addr[11:8] == $past(bank_select_register))
        else $error("bank not applied to banked address");

    chk_access_map: assert property (
        dec_valid && dec.cls == CLS_BIT && !dec.use_bank
        |-> dec.data_addr[11:8] == (dec.reg_addr < ACCESS_SPLIT ? ACCESS_LOW_BANK
                                                                : ACCESS_HIGH_BANK))
        else $error("access RAM mapping wrong");

    chk_bit_field: assert property (
        $past(tick_now) && dec_valid && dec.cls == CLS_BIT && !$past(flush_now)
        |-> dec.bit_pos == $past(instr_word[11:9]))
        else $error("bit position field wrong");

    chk_flush_nop: assert property (
        tick_now && take && flush_now |=> dec.cls == CLS_NOP && flush_req == $past(redirect))
        else $error("redirect did not insert no-op cycle");

    chk_tbl_mode: assert property (
        $past(tick_now) && dec_valid && dec.cls == CLS_TABLE
        |-> dec.tbl_mode == tbl_update_t'($past(instr_word[1:0])))
        else $error("table update mode wrong");

    chk_movff_addr: assert property (
        $past(tick_now) && dec_valid && dec.cls == CLS_MOVFF && !dec.pending
        |-> dec.dest_addr == $past(instr_word[11:0]) && !dec.use_bank)
        else $error("move destination address wrong");

    chk_flag_report: assert property (
        ce && flags_we[FLAG_ZERO] |=> status_flags[FLAG_ZERO] == $past(flags_in[FLAG_ZERO]))
        else $error("zero flag not reported");

    chk_bank_write: assert property (
        ce && apb_write && paddr == OFF_BANK && !bank_we
        |=> bank_select_register == $past(pwdata[BANK_W-1:0]))
        else $error("bank register write lost");

    cov_two_word: cover property (dec_valid && dec.pending ##4 dec_valid && !dec.pending);
    cov_flush: cover property (tick_now && take && flush_now);
    cov_table: cover property (dec_valid && dec.cls == CLS_TABLE);
    cov_ext: cover property (dec_valid && dec.cls == CLS_EXT);

endmodule // core_instruction_decoder

// [tb/fetch_model.sv]
// program memory fetch model: one word per instruction cycle
`timescale 1ns/1ns
module fetch_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic [3:0]  n_words,
    input  wire logic [15:0] prog [8],
    input  wire logic        cycle_tick,
    input  wire logic        dec_valid,
    output logic      [15:0] instr_word,
    output logic             instr_valid
);
    logic [3:0] ptr;
    // words leave in program order, second words right after the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ptr <= 4'h8;
        else if (start)
            ptr <= 4'h0;
        else if (cycle_tick && dec_valid && !ptr[3])
            ptr <= (ptr + 4'h1 >= n_words) ? 4'h8 : ptr + 4'h1;
    end
    assign instr_valid = !ptr[3];
    // idle bus shows the flipped last word so a stale value never matches
    assign instr_word = instr_valid ? prog[ptr[2:0]] : ~prog[3'(n_words - 4'h1)];
endmodule // fetch_model

// [tb/core_instruction_decoder_tb_top.sv]
// self-checking bench for the instruction decoder
`timescale 1ns/1ns
module core_instruction_decoder_tb_top;
    import core_decoder_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, redirect, start;
    logic              pready, pslverr, instr_valid, dec_valid, cycle_tick, err;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [15:0]       instr_word;
    logic [15:0]       prog [8];
    logic [3:0]        n_words;
    logic [FLAG_N-1:0] flags_in, flags_we, status_flags;
    logic [BANK_W-1:0] bank_select_register;
    decoded_t          dec;
    decoded_t          got [8];
    int                error_cnt, total_checks, cycles, n;

    core_instruction_decoder DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_word(instr_word), .instr_valid(instr_valid), .redirect(redirect),
        .bank_we(1'b0), .bank_wdata(4'h0), .flags_in(flags_in), .flags_we(flags_we),
        .dec(dec), .dec_valid(dec_valid), .cycle_tick(cycle_tick),
        .status_flags(status_flags), .bank_select_register(bank_select_register));
    fetch_model fetch (.pclk(pclk), .presetn(presetn), .start(start),
        .n_words(n_words), .prog(prog), .cycle_tick(cycle_tick),
        .dec_valid(dec_valid), .instr_word(instr_word), .instr_valid(instr_valid));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic close_out();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_tick();
        do @(negedge pclk); while (cycle_tick !== 1'b1);
    endtask
    // flush pulse optional; collects k decoded words
    task automatic run(input int k, input logic rdp);
        @(posedge pclk);
        n_words <= 4'(k);
        start <= 1'b1;
        redirect <= rdp;
        @(posedge pclk);
        start <= 1'b0;
        redirect <= 1'b0;
        for (int i = 0; i < k; i++) begin
            do wait_tick(); while (dec_valid !== 1'b1);
            got[i] = dec;
        end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd, {30'h0, CTRL_RESET});
        apb(1'b1, OFF_BANK, 32'h5);
        apb(1'b0, OFF_BANK, 32'h0);
        chk(rd, 32'h5);
        chk(32'(bank_select_register), 32'h5);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        @(posedge pclk);
        flags_in <= 5'h15;
        flags_we <= 5'h1F;
        @(posedge pclk);
        flags_in <= 5'h00;
        flags_we <= 5'h01;
        @(posedge pclk);
        flags_we <= 5'h00;
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(32'(rd[4:0]), 32'h14);
        chk(32'(status_flags), 32'h14);
    endtask
    task automatic t_byte();
        logic [11:0] e;
        prog[0] = 16'h2412;
        prog[1] = 16'h2770;
        prog[2] = 16'h6A80;
        run(3, 1'b0);
        for (int i = 0; i < 3; i++) begin
            e = prog[i][8] ? {4'h5, prog[i][7:0]} : (prog[i][7:0] < ACCESS_SPLIT ?
                {ACCESS_LOW_BANK, prog[i][7:0]} : {ACCESS_HIGH_BANK, prog[i][7:0]});
            chk(32'(got[i].cls), 32'(CLS_BYTE));
            chk(32'(got[i].use_bank), 32'(prog[i][8]));
            chk(32'(got[i].reg_addr), 32'(prog[i][7:0]));
            chk(32'(got[i].data_addr), 32'(e));
            chk(32'(got[i].cycles), 32'(CYC_ONE));
            if (i < 2)
                chk(32'(got[i].to_register), 32'(prog[i][9]));
        end
    endtask
    task automatic t_pairs();
        prog = '{16'hC123, 16'hF456, 16'hEF34, 16'hF567,
                 16'hEE2A, 16'hF0BC, 16'hED12, 16'hF345};
        run(8, 1'b0);
        chk(32'(got[0].cls), 32'(CLS_MOVFF));
        chk(32'(got[0].pending), 32'h1);
        chk(32'(got[0].cycles), 32'(CYC_TWO));
        chk(32'(got[0].data_addr), 32'h123);
        chk(32'(got[1].dest_addr), 32'h456);
        chk(32'(got[1].pending), 32'h0);
        chk(32'(got[2].cls), 32'(CLS_GOTO));
        chk(32'(got[3].target), 32'h56734);
        chk(32'(got[3].relative), 32'h0);
        chk(32'(got[4].cls), 32'(CLS_LFSR));
        chk(32'(got[5].literal), 32'hABC);
        chk(32'(got[5].ptr_sel), 32'h2);
        chk(32'(got[6].cls), 32'(CLS_CALL));
        chk(32'(got[7].target), 32'h34512);
        chk(32'(got[7].fast), 32'h1);
    endtask
    task automatic t_ext();
        prog[0] = 16'hF123;
        prog[1] = 16'h0014;
        run(2, 1'b0);
        chk(32'(got[0].cls), 32'(CLS_NOP));
        chk(32'(got[1].cls), 32'(CLS_NOP));
        apb(1'b1, OFF_CTRL, 32'h3);
        prog[0] = 16'h0014;
        run(1, 1'b0);
        chk(32'(got[0].cls), 32'(CLS_EXT));
        // refused while decode is off, word stays in place
        apb(1'b1, OFF_CTRL, 32'h0);
        prog[0] = 16'h2433;
        n_words <= 4'h1;
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        wait_tick();
        wait_tick();
        chk({31'h0, dec_valid}, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h1);
        do wait_tick(); while (dec_valid !== 1'b1);
        chk(32'(dec.reg_addr), 32'h33);
    endtask
    task automatic t_flush();
        prog[0] = 16'h2412;
        prog[1] = 16'h2433;
        run(2, 1'b1);
        chk(32'(got[0].cls), 32'(CLS_NOP));
        chk(32'(got[0].cycles), 32'(CYC_ONE));
        chk(32'(got[1].reg_addr), 32'h33);
        wait_tick();
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (cycle_tick !== 1'b1 && n < 9);
        chk(32'(n), 32'h4);
    endtask
    // bit, table, branch, return and literal forms
    task automatic t_misc();
        prog = '{16'h9A65, 16'h000D, 16'hD7FE, 16'hE2F0,
                 16'h0013, 16'h0E7F, 16'h0000, 16'h0000};
        run(6, 1'b0);
        chk(32'(got[0].cls), 32'(CLS_BIT));
        chk(32'(got[0].bit_pos), 32'h5);
        chk(32'(got[0].data_addr), 32'hF65);
        chk(32'(got[1].cls), 32'(CLS_TABLE));
        chk(32'(got[1].tbl_mode), 32'(TBL_POST_INC));
        chk(32'(got[2].target), 32'hFFFFE);
        chk(32'(got[2].cycles), 32'(CYC_TWO));
        chk(32'(got[3].target), 32'hFFFF0);
        chk(32'(got[4].fast), 32'h1);
        chk(32'(got[4].cycles), 32'(CYC_TWO));
        chk(32'(got[5].literal), 32'h7F);
        chk(32'(got[5].lit_width), 32'(LW_8));
    endtask

    // ****************************************
    // clock, reset, timeout, main sequence
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, redirect, start} = '0;
        paddr = '0;
        pwdata = '0;
        flags_in = '0;
        flags_we = '0;
        n_words = 4'h1;
        prog = '{default: 16'h0};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_byte();
        t_pairs();
        t_ext();
        t_flush();
        t_misc();
        close_out();
    end
endmodule // core_instruction_decoder_tb_top
